// ### rtl/irq_pkg.sv
package irq_pkg;
	// register addresses on the cpu special-function port
	localparam logic [15:0] REQ_FLAGS_ADDR = 16'hffe0;
	localparam logic [15:0] MASK_FLAGS_ADDR = 16'hffe4;
	localparam logic [15:0] EDGE_CFG_ADDR = 16'hffec;
	localparam logic [15:0] PSW_ADDR = 16'hff1e;
	// reset values
	localparam logic [7:0] REQ_FLAGS_RST = 8'h00;
	localparam logic [7:0] MASK_FLAGS_RST = 8'hff;
	localparam logic [7:0] EDGE_CFG_RST = 8'h00;
	localparam logic [7:0] PSW_RST = 8'h02;
	// bit positions of the four sources, shared by flag and mask registers
	localparam int LOWVOLT_BIT = 1;
	localparam int PIN_A_BIT = 2;
	localparam int PIN_B_BIT = 3;
	localparam int TIMER_BIT = 4;
	localparam logic [7:0] SRC_BITS = 8'h1e;
	// edge select fields
	localparam int PIN_A_EDGE_LO = 2;
	localparam int PIN_B_EDGE_LO = 4;
	localparam logic [7:0] EDGE_CFG_BITS = 8'h3c;
	// global accept bit inside the status word
	localparam int PSW_IE_BIT = 7;
	// edge selection codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BAD = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// vector entries
	localparam logic [15:0] VEC_LOWVOLT = 16'h0006;
	localparam logic [15:0] VEC_PIN_A = 16'h0008;
	localparam logic [15:0] VEC_PIN_B = 16'h000a;
	localparam logic [15:0] VEC_TIMER = 16'h000c;
	// acknowledge sequence states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PUSH_PSW = 2'b01,
		ST_PUSH_PC = 2'b10,
		ST_VECTOR = 2'b11
	} ack_state_t;
endpackage

// ### rtl/pin_edge_detect.sv
`timescale 1ns/1ns
module pin_edge_detect (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// raw pin and edge select
	input wire logic pin_i,
	input wire logic [1:0] edge_sel_i,
	// one-cycle event
	output logic evt_o
);
	logic sync1_r, sync1_nxt; // first synchroniser stage
	logic sync2_r, sync2_nxt; // second synchroniser stage
	logic prev_r, prev_nxt; // previous settled level
	logic [2:0] primed_r, primed_nxt; // one bit per pipe stage that holds a real pin sample
	logic evt_r, evt_nxt; // registered event

	// next values: shift the pin in, compare settled levels
	always_comb begin
		sync1_nxt = pin_i;
		sync2_nxt = sync1_r;
		prev_nxt = sync2_r;
		primed_nxt = {primed_r[1:0], 1'b1};
		evt_nxt = 1'b0;
		if (primed_r[2]) begin // no edge until prev and sync2 both hold real samples
			case (edge_sel_i)
				irq_pkg::EDGE_FALL: evt_nxt = prev_r & ~sync2_r;
				irq_pkg::EDGE_RISE: evt_nxt = ~prev_r & sync2_r;
				irq_pkg::EDGE_BOTH: evt_nxt = prev_r ^ sync2_r;
				default: evt_nxt = 1'b0; // prohibited code detects nothing
			endcase
		end
	end

	// registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
			primed_r <= 3'h0;
			evt_r <= 1'b0;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r <= prev_nxt;
			primed_r <= primed_nxt;
			evt_r <= evt_nxt;
		end
	end

	assign evt_o = evt_r;
endmodule

// ### rtl/maskable_interrupt_control.sv
`timescale 1ns/1ns
// Overview of operation
// RL1 - flag set by request or write, cleared on ack
// RL2 - request flags at ffe0, reset 00
// RL3 - flags and masks writable by bit or byte
// RL4 - mask flags at ffe4, reset ff, spare ones
// RL5 - mask 0 enables, masked flags still record
// RL6 - two edge bits per pin, 10 prohibited
// RL7 - edge config at ffec, byte writes, reset 00
// RL8 - software writes zero to spare edge bits
// RL9 - software masks before changing edge config
// RL10 - pin toggled as output sets its flag
// RL11 - status word holds accept bit, reset 02
// RL12 - status word byte/bit access, accept on/off
// RL13 - ack needs flag, no mask, accept bit set
// RL14 - servicing starts 9 to 19 clocks later
// RL15 - highest priority first, others stay pending
// RL16 - pending request taken once conditions hold
// RL17 - push status word, pc, clear, vector
// RL18 - return instruction restores interrupted program
// RL19 - flag before last clock: ack after instruction
// RL20 - flag at last clock: ack one instruction later
// RL21 - flag or mask access holds requests pending
// RL22 - priority lowvolt, pin a, pin b, timer
// RL23 - vectors 0006, 0008, 000a, 000c
// RL24 - pins sampled, flag set per matching edge
// RL25 - hardware set beats coincident software write
module maskable_interrupt_control (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// special-function register port from the cpu
	input wire logic [15:0] sfr_addr_i,
	input wire logic sfr_rd_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_bit_wr_i,
	input wire logic [2:0] sfr_bit_sel_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// dedicated instructions from the cpu
	input wire logic accept_on_i,
	input wire logic accept_off_i,
	input wire logic return_from_irq_instr_i,
	input wire logic [7:0] psw_pop_i,
	// instruction timing from the cpu
	input wire logic instr_last_clk_i,
	// request sources
	input wire logic lowvolt_irq_i,
	input wire logic timer_match_irq_i,
	input wire logic pin_a_i,
	input wire logic pin_b_i,
	// acknowledge sequence towards the cpu
	output logic ack_busy_o,
	output logic push_psw_o,
	output logic push_pc_o,
	output logic [7:0] push_data_o,
	output logic vec_load_o,
	output logic [15:0] vector_o,
	// status towards the cpu
	output logic [7:0] prog_state_word_o,
	output logic irq_pending_o
);
	// stored registers
	logic [7:0] req_flags_r, req_flags_nxt; // request flags
	logic [7:0] mask_flags_r, mask_flags_nxt; // mask flags
	logic [7:0] ext_edge_cfg_r, ext_edge_cfg_nxt; // edge selects
	logic [7:0] psw_r, psw_nxt; // program status word
	logic [7:0] rdata_r, rdata_nxt; // read data
	// acknowledge sequencing
	irq_pkg::ack_state_t state_r, state_nxt;
	logic [3:0] src_r, src_nxt; // one-hot source being taken
	logic [7:0] psw_save_r, psw_save_nxt; // word before ack
	logic hold_r, hold_nxt; // flag or mask touched this instruction
	logic busy_r, busy_nxt;
	logic push_psw_r, push_psw_nxt;
	logic push_pc_r, push_pc_nxt;
	logic vec_load_r, vec_load_nxt;
	logic [15:0] vector_r, vector_nxt;
	logic pending_r, pending_nxt;
	// combinational helpers
	logic pin_a_evt; // pin a matching edge
	logic pin_b_evt; // pin b matching edge
	logic [7:0] hw_set; // hardware requests this cycle
	logic [7:0] ready; // acknowledgeable sources
	logic [3:0] pick; // one-hot winner
	logic touch_fm; // access to flags or masks now
	logic take; // acknowledge starts now

	// pin edge detectors with synchronisers
	// edge select fields come straight from the stored config
	pin_edge_detect u_pin_a ( // [RL24]
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.pin_i(pin_a_i),
		.edge_sel_i(ext_edge_cfg_r[irq_pkg::PIN_A_EDGE_LO +: 2]), // [RL6]
		.evt_o(pin_a_evt)
	);
	pin_edge_detect u_pin_b ( // [RL24]
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.pin_i(pin_b_i),
		.edge_sel_i(ext_edge_cfg_r[irq_pkg::PIN_B_EDGE_LO +: 2]), // [RL6]
		.evt_o(pin_b_evt)
	);

	// request selection and acknowledge decision
	always_comb begin
		hw_set = 8'h00;
		hw_set[irq_pkg::LOWVOLT_BIT] = lowvolt_irq_i;
		hw_set[irq_pkg::PIN_A_BIT] = pin_a_evt; // output-mode toggles count too [RL10]
		hw_set[irq_pkg::PIN_B_BIT] = pin_b_evt;
		hw_set[irq_pkg::TIMER_BIT] = timer_match_irq_i;
		// flag set and mask clear [RL13] [RL5]
		ready = req_flags_r & ~mask_flags_r & irq_pkg::SRC_BITS;
		// fixed priority winner [RL15] [RL22]
		pick = 4'h0;
		if (ready[irq_pkg::LOWVOLT_BIT]) begin
			pick = 4'h1;
		end else if (ready[irq_pkg::PIN_A_BIT]) begin
			pick = 4'h2;
		end else if (ready[irq_pkg::PIN_B_BIT]) begin
			pick = 4'h4;
		end else if (ready[irq_pkg::TIMER_BIT]) begin
			pick = 4'h8;
		end
		touch_fm = (sfr_rd_i | sfr_wr_i | sfr_bit_wr_i) &
			((sfr_addr_i == irq_pkg::REQ_FLAGS_ADDR) | (sfr_addr_i == irq_pkg::MASK_FLAGS_ADDR));
		// deciding on registered flags keeps the request inputs off this path
		// taken at the end of an instruction, using flags from before its last clock [RL19] [RL20]
		// never at the end of an instruction that touched flags or masks [RL21]
		take = (state_r == irq_pkg::ST_IDLE) & instr_last_clk_i & ~hold_r & ~touch_fm &
			psw_r[irq_pkg::PSW_IE_BIT] & (|pick); // [RL13] [RL16]
	end

	// request flags, masks and edge config
	always_comb begin
		req_flags_nxt = req_flags_r;
		mask_flags_nxt = mask_flags_r;
		ext_edge_cfg_nxt = ext_edge_cfg_r;
		if (sfr_wr_i) begin
			// whole-byte writes [RL3]
			case (sfr_addr_i)
				irq_pkg::REQ_FLAGS_ADDR: req_flags_nxt = sfr_wdata_i & irq_pkg::SRC_BITS; // [RL2]
				irq_pkg::MASK_FLAGS_ADDR: mask_flags_nxt = sfr_wdata_i | ~irq_pkg::SRC_BITS; // [RL4]
				irq_pkg::EDGE_CFG_ADDR: ext_edge_cfg_nxt = sfr_wdata_i & irq_pkg::EDGE_CFG_BITS; // [RL7] [RL8]
				default: ;
			endcase
		end else if (sfr_bit_wr_i && irq_pkg::SRC_BITS[sfr_bit_sel_i]) begin
			// single-bit writes; the edge config ignores them [RL3] [RL7]
			if (sfr_addr_i == irq_pkg::REQ_FLAGS_ADDR) begin
				req_flags_nxt[sfr_bit_sel_i] = sfr_wdata_i[0];
			end else if (sfr_addr_i == irq_pkg::MASK_FLAGS_ADDR) begin
				mask_flags_nxt[sfr_bit_sel_i] = sfr_wdata_i[0];
			end
		end
		// take never meets a flag or mask write here, since touch_fm blocks it
		// acknowledged flag clears [RL1] [RL17]
		if (take) begin
			req_flags_nxt[irq_pkg::LOWVOLT_BIT] = req_flags_nxt[irq_pkg::LOWVOLT_BIT] & ~pick[0];
			req_flags_nxt[irq_pkg::PIN_A_BIT] = req_flags_nxt[irq_pkg::PIN_A_BIT] & ~pick[1];
			req_flags_nxt[irq_pkg::PIN_B_BIT] = req_flags_nxt[irq_pkg::PIN_B_BIT] & ~pick[2];
			req_flags_nxt[irq_pkg::TIMER_BIT] = req_flags_nxt[irq_pkg::TIMER_BIT] & ~pick[3];
		end
		// a request landing on the ack cycle re-arms its flag and is not lost
		// hardware set wins over any clear, masked or not [RL1] [RL5] [RL25]
		req_flags_nxt = req_flags_nxt | hw_set;
	end

	// register update for flags, masks and edge config
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			req_flags_r <= irq_pkg::REQ_FLAGS_RST; // [RL1] [RL2]
			mask_flags_r <= irq_pkg::MASK_FLAGS_RST; // [RL4]
			ext_edge_cfg_r <= irq_pkg::EDGE_CFG_RST; // [RL7]
		end else begin
			req_flags_r <= req_flags_nxt;
			mask_flags_r <= mask_flags_nxt;
			ext_edge_cfg_r <= ext_edge_cfg_nxt;
		end
	end

	// program status word and read port
	always_comb begin
		psw_nxt = psw_r;
		if (sfr_wr_i && sfr_addr_i == irq_pkg::PSW_ADDR) begin
			psw_nxt = sfr_wdata_i; // [RL12]
		end else if (sfr_bit_wr_i && sfr_addr_i == irq_pkg::PSW_ADDR) begin
			psw_nxt[sfr_bit_sel_i] = sfr_wdata_i[0]; // [RL12]
		end
		// dedicated instructions override a plain write to the same bit
		if (accept_on_i) begin
			psw_nxt[irq_pkg::PSW_IE_BIT] = 1'b1; // [RL12]
		end else if (accept_off_i) begin
			psw_nxt[irq_pkg::PSW_IE_BIT] = 1'b0; // [RL12]
		end
		// return restores the saved word [RL18]
		if (return_from_irq_instr_i) begin
			psw_nxt = psw_pop_i;
		end
		// acknowledge forbids further acceptance [RL17]
		if (take) begin
			psw_nxt[irq_pkg::PSW_IE_BIT] = 1'b0;
		end
		// read data holds between reads
		rdata_nxt = rdata_r;
		if (sfr_rd_i) begin
			case (sfr_addr_i)
				irq_pkg::REQ_FLAGS_ADDR: rdata_nxt = req_flags_r;
				irq_pkg::MASK_FLAGS_ADDR: rdata_nxt = mask_flags_r;
				irq_pkg::EDGE_CFG_ADDR: rdata_nxt = ext_edge_cfg_r;
				irq_pkg::PSW_ADDR: rdata_nxt = psw_r;
				default: rdata_nxt = 8'h00; // unmapped reads zero
			endcase
		end
	end

	// register update for status word and read data
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			psw_r <= irq_pkg::PSW_RST; // [RL11]
			rdata_r <= 8'h00;
		end else begin
			psw_r <= psw_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// acknowledge sequence: push word, push pc, load vector
	always_comb begin
		state_nxt = state_r;
		src_nxt = src_r;
		psw_save_nxt = psw_save_r;
		// remember a flag or mask access until the instruction ends [RL21]
		// cleared at each instruction end, so the hold spans one instruction
		hold_nxt = instr_last_clk_i ? 1'b0 : (hold_r | touch_fm);
		case (state_r)
			irq_pkg::ST_IDLE: begin
				if (take) begin
					state_nxt = irq_pkg::ST_PUSH_PSW;
					src_nxt = pick;
					psw_save_nxt = psw_r; // word as it was before the ack
				end
			end
			irq_pkg::ST_PUSH_PSW: state_nxt = irq_pkg::ST_PUSH_PC; // [RL17]
			irq_pkg::ST_PUSH_PC: state_nxt = irq_pkg::ST_VECTOR; // [RL17]
			irq_pkg::ST_VECTOR: state_nxt = irq_pkg::ST_IDLE;
			default: state_nxt = irq_pkg::ST_IDLE;
		endcase
		// strobes decode the next state so they leave straight from flops
		busy_nxt = (state_nxt != irq_pkg::ST_IDLE);
		push_psw_nxt = (state_nxt == irq_pkg::ST_PUSH_PSW); // word first [RL17]
		push_pc_nxt = (state_nxt == irq_pkg::ST_PUSH_PC); // pc second [RL17]
		vec_load_nxt = (state_nxt == irq_pkg::ST_VECTOR); // [RL14]
		// vector entry per source [RL23]
		// settles with the first push and holds through the load
		case (src_nxt)
			4'h1: vector_nxt = irq_pkg::VEC_LOWVOLT;
			4'h2: vector_nxt = irq_pkg::VEC_PIN_A;
			4'h4: vector_nxt = irq_pkg::VEC_PIN_B;
			4'h8: vector_nxt = irq_pkg::VEC_TIMER;
			default: vector_nxt = 16'h0000;
		endcase
		// acknowledgeable regardless of accept bit, for standby release
		pending_nxt = |(req_flags_nxt & ~mask_flags_nxt & irq_pkg::SRC_BITS);
	end

	// register update for the acknowledge sequence
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= irq_pkg::ST_IDLE;
			src_r <= 4'h0;
			psw_save_r <= irq_pkg::PSW_RST;
			hold_r <= 1'b0;
			busy_r <= 1'b0;
			push_psw_r <= 1'b0;
			push_pc_r <= 1'b0;
			vec_load_r <= 1'b0;
			vector_r <= 16'h0000;
			pending_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			src_r <= src_nxt;
			psw_save_r <= psw_save_nxt;
			hold_r <= hold_nxt;
			busy_r <= busy_nxt;
			push_psw_r <= push_psw_nxt;
			push_pc_r <= push_pc_nxt;
			vec_load_r <= vec_load_nxt;
			vector_r <= vector_nxt;
			pending_r <= pending_nxt;
		end
	end

	// outputs straight from flops
	assign sfr_rdata_o = rdata_r;
	assign ack_busy_o = busy_r;
	assign push_psw_o = push_psw_r;
	assign push_pc_o = push_pc_r;
	assign push_data_o = psw_save_r;
	assign vec_load_o = vec_load_r;
	assign vector_o = vector_r;
	assign prog_state_word_o = psw_r;
	assign irq_pending_o = pending_r;
endmodule

// ### tb/irq_ctl_sva.sv
`timescale 1ns/1ns
module irq_ctl_sva (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// register port
	input wire logic [15:0] sfr_addr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_rdata_o,
	// cpu instructions
	input wire logic accept_on_i,
	input wire logic accept_off_i,
	input wire logic return_from_irq_instr_i,
	input wire logic [7:0] psw_pop_i,
	input wire logic instr_last_clk_i,
	// acknowledge side
	input wire logic ack_busy_o,
	input wire logic push_psw_o,
	input wire logic push_pc_o,
	input wire logic [7:0] push_data_o,
	input wire logic vec_load_o,
	input wire logic [15:0] vector_o,
	input wire logic [7:0] prog_state_word_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);
	// strobes follow one another
	AST_PUSH_SEQ: assert property (push_psw_o |=> push_pc_o && !push_psw_o ##1 vec_load_o && !push_pc_o)
		else $error("push strobes out of order");
	AST_BUSY_LEN: assert property (push_psw_o |-> ack_busy_o [*3] ##1 !ack_busy_o)
		else $error("busy length wrong");
	// take only at an instruction end with accept set
	AST_TAKE_COND: assert property (push_psw_o |-> $past(instr_last_clk_i) && $past(prog_state_word_o[7]))
		else $error("take without end or accept");
	AST_ACCEPT_CLR: assert property (push_psw_o |-> !prog_state_word_o[7])
		else $error("accept bit not cleared");
	AST_PUSH_DATA: assert property (push_psw_o |-> push_data_o == $past(prog_state_word_o))
		else $error("pushed status word wrong");
	AST_VEC_HOLD: assert property (push_psw_o |=> $stable(vector_o) [*2])
		else $error("vector moved");
	// dedicated instructions
	AST_ACCEPT_ON: assert property (accept_on_i && !return_from_irq_instr_i && !instr_last_clk_i |=> prog_state_word_o[7])
		else $error("accept on lost");
	AST_ACCEPT_OFF: assert property (accept_off_i && !accept_on_i && !return_from_irq_instr_i |=> !prog_state_word_o[7])
		else $error("accept off lost");
	AST_RETURN_FROM_IRQ_INSTR_LOAD: assert property (return_from_irq_instr_i && !instr_last_clk_i |=> prog_state_word_o == $past(psw_pop_i))
		else $error("status word not restored");
	// spare bits of flags and masks
	AST_MASK_SPARE: assert property (sfr_rd_i && sfr_addr_i == irq_pkg::MASK_FLAGS_ADDR |=> (sfr_rdata_o | irq_pkg::SRC_BITS) == 8'hff)
		else $error("mask spare bits not one");
	AST_FLAG_SPARE: assert property (sfr_rd_i && sfr_addr_i == irq_pkg::REQ_FLAGS_ADDR |=> (sfr_rdata_o & ~irq_pkg::SRC_BITS) == 8'h00)
		else $error("flag spare bits not zero");
	// main scenarios
	COV_TIMER_VEC: cover property (push_psw_o && vector_o == irq_pkg::VEC_TIMER);
	COV_RETURN_FROM_IRQ_INSTR: cover property (return_from_irq_instr_i);
	COV_MASK_RD: cover property (sfr_rd_i && sfr_addr_i == irq_pkg::MASK_FLAGS_ADDR);
endmodule
bind maskable_interrupt_control irq_ctl_sva irq_ctl_sva_inst (
	.clk_i(clk_i),
	.nrst_i(nrst_i),
	.sfr_addr_i(sfr_addr_i),
	.sfr_rd_i(sfr_rd_i),
	.sfr_rdata_o(sfr_rdata_o),
	.accept_on_i(accept_on_i),
	.accept_off_i(accept_off_i),
	.return_from_irq_instr_i(return_from_irq_instr_i),
	.psw_pop_i(psw_pop_i),
	.instr_last_clk_i(instr_last_clk_i),
	.ack_busy_o(ack_busy_o),
	.push_psw_o(push_psw_o),
	.push_pc_o(push_pc_o),
	.push_data_o(push_data_o),
	.vec_load_o(vec_load_o),
	.vector_o(vector_o),
	.prog_state_word_o(prog_state_word_o)
);

// ### tb/cpu_model.sv
`timescale 1ns/1ns
module cpu_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// instruction length and acknowledge stall
	input wire logic [3:0] len_i,
	input wire logic busy_i,
	// end of instruction marker
	output logic last_clk_o
);
	logic [3:0] cnt_r; // clock within the instruction
	// instructions of len_i clocks, frozen while the acknowledge runs
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r <= 4'h0;
		end else if (busy_i || last_clk_o) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	assign last_clk_o = !busy_i && (cnt_r == len_i - 4'h1);
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic clk_i, nrst_i, sfr_rd_i, sfr_wr_i, sfr_bit_wr_i, accept_on_i, accept_off_i, return_from_irq_instr_i;
	logic lowvolt_irq_i, timer_match_irq_i, pin_a_i, pin_b_i, rd_pend, pd_look;
	logic [15:0] sfr_addr_i;
	logic [2:0] sfr_bit_sel_i;
	logic [7:0] sfr_wdata_i, psw_pop_i, v, cfg;
	logic [3:0] ilen;
	wire logic instr_last_clk_i, ack_busy_o, push_psw_o, push_pc_o, vec_load_o, irq_pending_o;
	wire logic [7:0] sfr_rdata_o, push_data_o, prog_state_word_o;
	wire logic [15:0] vector_o;
	logic [7:0] exp_rd[$]; // expected read data
	logic [23:0] exp_ack[$]; // expected vector and pushed word
	logic exp_pd[$]; // expected pending level
	int bad_count, num_checks, i, c, p, r, n;
	maskable_interrupt_control maskable_interrupt_control_inst (
		.clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_wr_i(sfr_wr_i), .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_sel_i(sfr_bit_sel_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .accept_on_i(accept_on_i),
		.accept_off_i(accept_off_i), .return_from_irq_instr_i(return_from_irq_instr_i), .psw_pop_i(psw_pop_i),
		.instr_last_clk_i(instr_last_clk_i), .lowvolt_irq_i(lowvolt_irq_i),
		.timer_match_irq_i(timer_match_irq_i), .pin_a_i(pin_a_i), .pin_b_i(pin_b_i),
		.ack_busy_o(ack_busy_o), .push_psw_o(push_psw_o), .push_pc_o(push_pc_o),
		.push_data_o(push_data_o), .vec_load_o(vec_load_o), .vector_o(vector_o),
		.prog_state_word_o(prog_state_word_o), .irq_pending_o(irq_pending_o));
	cpu_model cpu_model_inst (.clk_i, .nrst_i, .len_i(ilen), .busy_i(ack_busy_o), .last_clk_o(instr_last_clk_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic complete_run;
		if (exp_rd.size() + exp_ack.size() + exp_pd.size() > 0) begin
			bad_count++;
			$display("[FAIL] %0t expected results left unchecked", $time);
		end
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// one register access: op 0 read, 1 byte write, 2 bit write
	task automatic sfr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] op, input logic [2:0] s);
		@(posedge clk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_bit_sel_i <= s;
		sfr_rd_i <= (op == 2'h0);
		sfr_wr_i <= (op == 2'h1);
		sfr_bit_wr_i <= (op == 2'h2);
		@(posedge clk_i);
		sfr_rd_i <= 1'b0;
		sfr_wr_i <= 1'b0;
		sfr_bit_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_rd.push_back(e);
		sfr(a, 8'h00, 2'h0, 3'h0);
	endtask
	task automatic chk_rd(input logic [7:0] got);
		logic [7:0] e;
		e = (exp_rd.size() > 0) ? exp_rd.pop_front() : 8'hxx;
		num_checks++;
		if (got !== e) begin
			bad_count++;
			$display("[FAIL] %0t read got %h expected %h", $time, got, e);
		end
	endtask
	task automatic chk_ack(input logic [23:0] got);
		logic [23:0] e;
		e = (exp_ack.size() > 0) ? exp_ack.pop_front() : 24'hxx_xxxx;
		num_checks++;
		if (got !== e) begin
			bad_count++;
			$display("[FAIL] %0t ack got %h expected %h", $time, got, e);
		end
	endtask
	// pending level look: note the expectation, then flag the watcher for one cycle
	task automatic pend(input logic e);
		exp_pd.push_back(e);
		@(posedge clk_i);
		pd_look <= 1'b1;
		@(posedge clk_i);
		pd_look <= 1'b0;
	endtask
	task automatic chk_pd(input logic got);
		logic e;
		e = (exp_pd.size() > 0) ? exp_pd.pop_front() : 1'bx;
		num_checks++;
		if (got !== e) begin
			bad_count++;
			$display("[FAIL] %0t pending got %b expected %b", $time, got, e);
		end
	endtask
	// watcher: read data one cycle after the strobe, ack at the push strobe
	always @(negedge clk_i) begin
		if (rd_pend === 1'b1) begin
			chk_rd(sfr_rdata_o);
		end
		rd_pend = sfr_rd_i;
		if (pd_look === 1'b1) begin
			chk_pd(irq_pending_o);
		end
		if (push_psw_o === 1'b1) begin
			chk_ack({vector_o, push_data_o});
		end
	end
	initial begin
		{sfr_rd_i, sfr_wr_i, sfr_bit_wr_i, accept_on_i, accept_off_i, return_from_irq_instr_i, rd_pend, pd_look} = 8'h00;
		{lowvolt_irq_i, timer_match_irq_i, pin_a_i, pin_b_i} = 4'h0;
		{sfr_addr_i, sfr_bit_sel_i, sfr_wdata_i, psw_pop_i} = 35'h0_0000_0000;
		nrst_i = 1'b0;
		ilen = 4'h4;
		v = 8'($urandom(49210));
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		// reset values and an unmapped place
		rd(irq_pkg::REQ_FLAGS_ADDR, 8'h00);
		rd(irq_pkg::MASK_FLAGS_ADDR, 8'hff);
		rd(irq_pkg::EDGE_CFG_ADDR, 8'h00);
		rd(irq_pkg::PSW_ADDR, 8'h02);
		rd(16'hff00, 8'h00);
		$display("test reset values done");
		// byte and bit writes, spare bits
		v = 8'($urandom);
		sfr(irq_pkg::MASK_FLAGS_ADDR, v, 2'h1, 3'h0);
		sfr(irq_pkg::MASK_FLAGS_ADDR, 8'h00, 2'h2, 3'h1);
		sfr(irq_pkg::MASK_FLAGS_ADDR, 8'h00, 2'h2, 3'h7);
		rd(irq_pkg::MASK_FLAGS_ADDR, (v | 8'he1) & 8'hfd);
		v = 8'($urandom);
		sfr(irq_pkg::REQ_FLAGS_ADDR, v, 2'h1, 3'h0);
		sfr(irq_pkg::REQ_FLAGS_ADDR, 8'h01, 2'h2, 3'h4);
		rd(irq_pkg::REQ_FLAGS_ADDR, (v & 8'h1e) | 8'h10);
		sfr(irq_pkg::EDGE_CFG_ADDR, 8'h3c, 2'h1, 3'h0);
		sfr(irq_pkg::EDGE_CFG_ADDR, 8'h00, 2'h2, 3'h2);
		rd(irq_pkg::EDGE_CFG_ADDR, 8'h3c);
		sfr(irq_pkg::MASK_FLAGS_ADDR, 8'hff, 2'h1, 3'h0);
		sfr(irq_pkg::PSW_ADDR, 8'h5a, 2'h1, 3'h0);
		sfr(irq_pkg::PSW_ADDR, 8'h01, 2'h2, 3'h0);
		rd(irq_pkg::PSW_ADDR, 8'h5b);
		sfr(irq_pkg::PSW_ADDR, irq_pkg::PSW_RST, 2'h1, 3'h0);
		$display("test register access done");
		// masked sources still record; set beats a coincident clear
		fork
			sfr(irq_pkg::REQ_FLAGS_ADDR, 8'h00, 2'h1, 3'h0);
			begin
				@(posedge clk_i);
				lowvolt_irq_i <= 1'b1;
				@(posedge clk_i);
				lowvolt_irq_i <= 1'b0;
				timer_match_irq_i <= 1'b1;
				@(posedge clk_i);
				timer_match_irq_i <= 1'b0;
			end
		join
		rd(irq_pkg::REQ_FLAGS_ADDR, 8'h12);
		pend(1'b0);
		$display("test masked recording done");
		// every edge code on both pins, rising then falling
		for (c = 0; c < 4; c++) begin
			for (p = 0; p < 2; p++) begin
				cfg = p ? {2'h0, c[1:0], 4'h0} : {4'h0, c[1:0], 2'h0};
				sfr(irq_pkg::EDGE_CFG_ADDR, cfg, 2'h1, 3'h0);
				for (r = 0; r < 2; r++) begin
					sfr(irq_pkg::REQ_FLAGS_ADDR, 8'h00, 2'h1, 3'h0);
					if (p == 1) pin_b_i <= ~pin_b_i;
					else pin_a_i <= ~pin_a_i;
					repeat (6) @(posedge clk_i);
					n = (c == 3) || (c == 1 && r == 0) || (c == 0 && r == 1);
					rd(irq_pkg::REQ_FLAGS_ADDR, n ? (p ? 8'h08 : 8'h04) : 8'h00);
				end
			end
		end
		$display("test edge select done");
		// pending with accept clear, then priority order of takes
		ilen <= 4'(4 + $urandom % 7);
		sfr(irq_pkg::MASK_FLAGS_ADDR, 8'h00, 2'h1, 3'h0);
		sfr(irq_pkg::REQ_FLAGS_ADDR, 8'h1e, 2'h1, 3'h0);
		repeat (40) @(posedge clk_i);
		pend(1'b1);
		exp_ack.push_back({irq_pkg::VEC_LOWVOLT, 8'h82});
		exp_ack.push_back({irq_pkg::VEC_PIN_A, 8'h82});
		exp_ack.push_back({irq_pkg::VEC_PIN_B, 8'h82});
		exp_ack.push_back({irq_pkg::VEC_TIMER, 8'h82});
		accept_on_i <= 1'b1;
		@(posedge clk_i);
		accept_on_i <= 1'b0;
		for (i = 0; i < 4; i++) begin
			n = 0;
			while (vec_load_o !== 1'b1 && n < 200) begin
				@(negedge clk_i);
				n++;
			end
			if (n == 200) begin
				bad_count++;
				$display("[FAIL] %0t no vector load", $time);
				complete_run;
			end
			@(posedge clk_i);
			return_from_irq_instr_i <= 1'b1;
			psw_pop_i <= 8'h82;
			@(posedge clk_i);
			return_from_irq_instr_i <= 1'b0;
		end
		accept_off_i <= 1'b1;
		@(posedge clk_i);
		accept_off_i <= 1'b0;
		rd(irq_pkg::PSW_ADDR, 8'h02);
		rd(irq_pkg::REQ_FLAGS_ADDR, 8'h00);
		pend(1'b0);
		repeat (4) @(posedge clk_i);
		$display("test acknowledge done");
		complete_run;
	end
endmodule
